/* File: include/mwi_map.svh */
`ifndef MWI_MAP_SVH
`define MWI_MAP_SVH

// Register byte offsets
`define MWI_OFS_IRQ_MASK 12'h300
`define MWI_OFS_IRQ_SET 12'h304
`define MWI_OFS_IRQ_CLR 12'h308
`define MWI_OFS_NMI_MASK 12'h320
`define MWI_OFS_EVT_STAT 12'h340

// Field positions of the event bits
`define MWI_CFG_LSB 0
`define MWI_PER_LSB 24
`define MWI_CFG_WINDOWS 4
`define MWI_PER_WINDOWS 2

// Implemented bits and reset values
`define MWI_VALID_BITS 32'h0f0000ff
`define MWI_RST_IRQ_MASK 32'h00000000
`define MWI_RST_NMI_MASK 32'h00000000
`define MWI_RST_EVT_STAT 32'h00000000

// Bus answer latency in cycles after the request is seen
`define MWI_ACK_LATENCY 1

`endif

/* File: include/mwi_pkg.sv */
package mwi_pkg;

  typedef enum logic [1:0] {
    MWI_BUS_IDLE = 2'b00,
    MWI_BUS_RESP = 2'b01
  } mwi_bus_state_t;

  typedef enum logic [1:0] {
    MWI_WR_NONE = 2'b00,
    MWI_WR_DIRECT = 2'b01,
    MWI_WR_SET = 2'b11,
    MWI_WR_CLEAR = 2'b10
  } mwi_wr_kind_t;

endpackage

/* File: core/mwi_en_reg.sv */
`timescale 1ns/1ns
`default_nettype none
`include "mwi_map.svh"

module mwi_en_reg #(
  parameter logic [31:0] RST_VAL = 32'h00000000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire mwi_pkg::mwi_wr_kind_t kind_i,
  input wire logic [31:0] wdata_i,
  input wire logic [31:0] bmask_i,
  output logic [31:0] en_ff_o
);

  logic [31:0] nxt_en;
  logic [31:0] hit;

  assign hit = wdata_i & bmask_i & `MWI_VALID_BITS;

  // A zero in set or clear data leaves the bit alone
  always_comb begin
    case (kind_i)
      mwi_pkg::MWI_WR_DIRECT: nxt_en = (en_ff_o & ~(bmask_i & `MWI_VALID_BITS))
                                       | hit;
      mwi_pkg::MWI_WR_SET: nxt_en = en_ff_o | hit; // [RULE10]
      mwi_pkg::MWI_WR_CLEAR: nxt_en = en_ff_o & ~hit; // [RULE10]
      default: nxt_en = en_ff_o;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_ff_o <= RST_VAL;
    end else begin
      en_ff_o <= nxt_en;
    end
  end

endmodule
`default_nettype wire

/* File: core/mwi_evt_latch.sv */
`timescale 1ns/1ns
`default_nettype none
`include "mwi_map.svh"

module mwi_evt_latch (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] evt_i,
  input wire logic clr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [31:0] bmask_i,
  output logic [31:0] pend_ff_o
);

  logic [31:0] clr_bits;

  assign clr_bits = clr_i ? (wdata_i & bmask_i) : 32'h00000000;

  // Set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_ff_o <= `MWI_RST_EVT_STAT;
    end else begin
      pend_ff_o <= ((pend_ff_o & ~clr_bits) | evt_i) & `MWI_VALID_BITS;
    end
  end

endmodule
`default_nettype wire

/* File: core/mwi_top.sv */
// Notes on behaviour
// [RULE1] One interrupt enable bit per window write hit and read hit; 1 allows.
// [RULE2] Configurable window read hits have enable bits apart from write hits.
// [RULE3] Writing 1 to the set alias sets enables; reading returns enables.
// [RULE4] Writing 1 to the clear alias clears enables; reading returns enables.
// [RULE5] Both peripheral windows have write and read hit enable bits too.
// [RULE6] Set alias enables each peripheral window event with a written 1.
// [RULE7] Clear alias disables each peripheral window event with a written 1.
// [RULE8] A separate per-event enable routes events to the NMI; 1 enables.
// [RULE9] Each watched window raises separate write hit and read hit events.
// [RULE10] Zeros written to set or clear aliases leave enables unchanged.
// [RULE11] IRQ is OR of pending events ANDed with enables; NMI likewise with NMI mask.
`timescale 1ns/1ns
`default_nettype none
`include "mwi_map.svh"

module mwi_top (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [5:0] evt_write_hit_i,
  input wire logic [5:0] evt_read_hit_i,
  output logic irq_o,
  output logic nmi_o
);

  mwi_pkg::mwi_bus_state_t bus_ff;
  mwi_pkg::mwi_bus_state_t nxt_bus;
  mwi_pkg::mwi_wr_kind_t irq_kind;
  mwi_pkg::mwi_wr_kind_t nmi_kind;

  logic req;
  logic wr_fire;
  logic [31:0] bmask;
  logic [31:0] evt_vec;
  logic [31:0] irq_en_ff;
  logic [31:0] nmi_en_ff;
  logic [31:0] pend_ff;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic irq_ff;
  logic nmi_ff;
  logic evt_clr;

  // Byte enables to a bit mask; used for every write path
  function automatic logic [31:0] sel_mask(input logic [3:0] sel);
    logic [31:0] m;
    m = 32'h00000000;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        m[i*8 +: 8] = 8'hff;
      end
    end
    return m;
  endfunction

  // Configurable windows take bits 0..7, peripheral windows 24..27,
  // write hit on the even bit and read hit on the odd bit of each pair
  function automatic logic [31:0] pack_events(input logic [5:0] wr,
                                               input logic [5:0] rd);
    logic [31:0] v;
    v = 32'h00000000;
    for (int k = 0; k < `MWI_CFG_WINDOWS; k++) begin
      v[`MWI_CFG_LSB + 2*k] = wr[k];
      v[`MWI_CFG_LSB + 2*k + 1] = rd[k];
    end
    for (int p = 0; p < `MWI_PER_WINDOWS; p++) begin
      v[`MWI_PER_LSB + 2*p] = wr[`MWI_CFG_WINDOWS + p];
      v[`MWI_PER_LSB + 2*p + 1] = rd[`MWI_CFG_WINDOWS + p];
    end
    return v;
  endfunction

  function automatic logic adr_is(input logic [11:0] adr,
                                  input logic [11:0] ofs);
    return adr[11:2] == ofs[11:2];
  endfunction

  // Events come from the watch logic on this clock: no synchroniser
  assign evt_vec = pack_events(evt_write_hit_i, evt_read_hit_i); // [RULE9]

  // Wishbone classic slave: one wait state, ack for one cycle
  assign req = wb_cyc_i & wb_stb_i;
  assign wb_ack_o = (bus_ff == mwi_pkg::MWI_BUS_RESP);
  assign bmask = sel_mask(wb_sel_i);
  // Writes land on the edge where the master samples ack
  assign wr_fire = req & wb_we_i & wb_ack_o;

  always_comb begin
    case (bus_ff)
      mwi_pkg::MWI_BUS_IDLE: begin
        nxt_bus = req ? mwi_pkg::MWI_BUS_RESP : mwi_pkg::MWI_BUS_IDLE;
      end
      mwi_pkg::MWI_BUS_RESP: nxt_bus = mwi_pkg::MWI_BUS_IDLE;
      default: nxt_bus = mwi_pkg::MWI_BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_ff <= mwi_pkg::MWI_BUS_IDLE;
    end else begin
      bus_ff <= nxt_bus;
    end
  end

  // Write decode into the two enable registers and the event status clear
  always_comb begin
    irq_kind = mwi_pkg::MWI_WR_NONE;
    nmi_kind = mwi_pkg::MWI_WR_NONE;
    evt_clr = 1'b0;
    if (wr_fire) begin
      if (adr_is(wb_adr_i, `MWI_OFS_IRQ_MASK)) begin
        irq_kind = mwi_pkg::MWI_WR_DIRECT; // [RULE1]
      end else if (adr_is(wb_adr_i, `MWI_OFS_IRQ_SET)) begin
        irq_kind = mwi_pkg::MWI_WR_SET; // [RULE3] [RULE6]
      end else if (adr_is(wb_adr_i, `MWI_OFS_IRQ_CLR)) begin
        irq_kind = mwi_pkg::MWI_WR_CLEAR; // [RULE4] [RULE7]
      end else if (adr_is(wb_adr_i, `MWI_OFS_NMI_MASK)) begin
        nmi_kind = mwi_pkg::MWI_WR_DIRECT; // [RULE8]
      end else if (adr_is(wb_adr_i, `MWI_OFS_EVT_STAT)) begin
        evt_clr = 1'b1;
      end
    end
  end

  // Same layout holds the read hit and peripheral bits [RULE2] [RULE5]
  mwi_en_reg #(
    .RST_VAL(`MWI_RST_IRQ_MASK)
  ) u_irq_en (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .kind_i(irq_kind),
    .wdata_i(wb_dat_i),
    .bmask_i(bmask),
    .en_ff_o(irq_en_ff)
  );

  mwi_en_reg #(
    .RST_VAL(`MWI_RST_NMI_MASK)
  ) u_nmi_en (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .kind_i(nmi_kind),
    .wdata_i(wb_dat_i),
    .bmask_i(bmask),
    .en_ff_o(nmi_en_ff)
  );

  mwi_evt_latch u_evt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .evt_i(evt_vec),
    .clr_i(evt_clr),
    .wdata_i(wb_dat_i),
    .bmask_i(bmask),
    .pend_ff_o(pend_ff)
  );

  // Read data is captured on the request edge so it is stable with ack;
  // unmapped addresses answer with zero rather than hang the bus
  always_comb begin
    nxt_rdata = 32'h00000000;
    if (adr_is(wb_adr_i, `MWI_OFS_IRQ_MASK) ||
        adr_is(wb_adr_i, `MWI_OFS_IRQ_SET) ||
        adr_is(wb_adr_i, `MWI_OFS_IRQ_CLR)) begin
      nxt_rdata = irq_en_ff; // [RULE3] [RULE4]
    end else if (adr_is(wb_adr_i, `MWI_OFS_NMI_MASK)) begin
      nxt_rdata = nmi_en_ff;
    end else if (adr_is(wb_adr_i, `MWI_OFS_EVT_STAT)) begin
      nxt_rdata = pend_ff;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_ff <= 32'h00000000;
    end else if (req && !wb_ack_o && !wb_we_i) begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign wb_dat_o = rdata_ff;

  // Outputs are registered to keep the request lines glitch free
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_ff <= 1'b0;
      nmi_ff <= 1'b0;
    end else begin
      irq_ff <= |(pend_ff & irq_en_ff); // [RULE11]
      nmi_ff <= |(pend_ff & nmi_en_ff); // [RULE8] [RULE11]
    end
  end

  assign irq_o = irq_ff;
  assign nmi_o = nmi_ff;

  default clocking mwi_cb @(posedge clk_i);
  endclocking

  default disable iff (rst_i);

  logic set_bit0;
  logic set_bit24;
  logic clr_bit0;
  logic clr_bit24;
  logic zero_set0;

  assign set_bit0 = (irq_kind == mwi_pkg::MWI_WR_SET) & wb_dat_i[0]
                    & wb_sel_i[0];
  assign set_bit24 = (irq_kind == mwi_pkg::MWI_WR_SET) & wb_dat_i[24]
                     & wb_sel_i[3];
  assign clr_bit0 = (irq_kind == mwi_pkg::MWI_WR_CLEAR) & wb_dat_i[0]
                    & wb_sel_i[0];
  assign clr_bit24 = (irq_kind == mwi_pkg::MWI_WR_CLEAR) & wb_dat_i[24]
                     & wb_sel_i[3];
  assign zero_set0 = (irq_kind == mwi_pkg::MWI_WR_SET ||
                      irq_kind == mwi_pkg::MWI_WR_CLEAR) & !wb_dat_i[0];

  chk_direct_write: assert property ( // [RULE1]
    (irq_kind == mwi_pkg::MWI_WR_DIRECT) && (wb_sel_i == 4'hf)
    |=> irq_en_ff == ($past(wb_dat_i) & `MWI_VALID_BITS))
    else $error("direct write did not load interrupt enables");

  chk_read_split: assert property ( // [RULE2]
    evt_read_hit_i[1] && !evt_write_hit_i[1] && !evt_clr
    |=> pend_ff[3] && ($past(pend_ff[2]) == pend_ff[2]))
    else $error("read hit of window 1 touched the write hit bit");

  chk_set_alias: assert property ( // [RULE3]
    set_bit0 |=> irq_en_ff[0])
    else $error("set alias did not enable bit 0");

  chk_alias_read: assert property ( // [RULE3]
    req && !wb_we_i && !wb_ack_o && adr_is(wb_adr_i, `MWI_OFS_IRQ_SET)
    |=> wb_ack_o && (wb_dat_o == irq_en_ff))
    else $error("set alias read did not return enables");

  chk_clr_alias: assert property ( // [RULE4]
    clr_bit0 |=> !irq_en_ff[0])
    else $error("clear alias did not disable bit 0");

  chk_periph_bits: assert property ( // [RULE5]
    evt_write_hit_i[5] && !evt_clr |=> pend_ff[26])
    else $error("peripheral window 1 write hit not at bit 26");

  chk_periph_set: assert property ( // [RULE6]
    set_bit24 |=> irq_en_ff[24])
    else $error("set alias did not enable peripheral bit 24");

  chk_periph_clr: assert property ( // [RULE7]
    clr_bit24 |=> !irq_en_ff[24])
    else $error("clear alias did not disable peripheral bit 24");

  chk_nmi_route: assert property ( // [RULE8]
    pend_ff[0] && nmi_en_ff[0] ##1 pend_ff[0] && nmi_en_ff[0] |-> nmi_o)
    else $error("enabled pending event did not raise nmi");

  chk_event_pair: assert property ( // [RULE9]
    evt_write_hit_i[0] |=> pend_ff[0])
    else $error("write hit of window 0 not latched");

  chk_zero_keeps: assert property ( // [RULE10]
    zero_set0 |=> $stable(irq_en_ff[0]))
    else $error("zero written to an alias changed bit 0");

  chk_irq_or: assert property ( // [RULE11]
    ##1 irq_o == $past(|(pend_ff & irq_en_ff)))
    else $error("irq does not follow pending and enabled events");

  chk_ack_pulse: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  chk_reserved_zero: assert property (
    wb_ack_o && !wb_we_i |-> (wb_dat_o & ~`MWI_VALID_BITS) == 32'h00000000)
    else $error("reserved bits read as non zero");

  // The default disable would hide reset itself, so it is switched off here
  chk_reset_clear: assert property (
    @(posedge clk_i) disable iff (1'b0)
    rst_i |=> !wb_ack_o && !irq_o && !nmi_o && (wb_dat_o == 32'h00000000)
    && (irq_en_ff == 32'h00000000) && (nmi_en_ff == 32'h00000000)
    && (pend_ff == 32'h00000000))
    else $error("reset left state or outputs set");

  chk_nmi_direct: assert property ( // [RULE8]
    (nmi_kind == mwi_pkg::MWI_WR_DIRECT) && (wb_sel_i == 4'hf)
    |=> nmi_en_ff == ($past(wb_dat_i) & `MWI_VALID_BITS))
    else $error("direct write did not load nmi enables");

  chk_set_only_sets: assert property ( // [RULE3] [RULE10]
    irq_kind == mwi_pkg::MWI_WR_SET
    |=> (irq_en_ff & $past(irq_en_ff)) == $past(irq_en_ff))
    else $error("set alias cleared an enable bit");

  chk_clr_only_clears: assert property ( // [RULE4] [RULE10]
    irq_kind == mwi_pkg::MWI_WR_CLEAR
    |=> (irq_en_ff & ~$past(irq_en_ff)) == 32'h00000000)
    else $error("clear alias set an enable bit");

  chk_idle_keeps: assert property ( // [RULE10]
    irq_kind == mwi_pkg::MWI_WR_NONE |=> $stable(irq_en_ff))
    else $error("interrupt enables changed without a write");

  chk_irq_blocked: assert property ( // [RULE1]
    irq_en_ff == 32'h00000000 |=> !irq_o)
    else $error("irq raised with all enables off");

  chk_nmi_blocked: assert property ( // [RULE8]
    nmi_en_ff == 32'h00000000 |=> !nmi_o)
    else $error("nmi raised with all nmi enables off");

  chk_nmi_or: assert property ( // [RULE11]
    ##1 nmi_o == $past(|(pend_ff & nmi_en_ff)))
    else $error("nmi does not follow pending and enabled events");

  chk_periph_read: assert property ( // [RULE5]
    evt_read_hit_i[4] |=> pend_ff[25])
    else $error("peripheral window 0 read hit not at bit 25");

  chk_ack_latency: assert property (
    req && !wb_ack_o |=> wb_ack_o)
    else $error("ack not given one cycle after the request");

  chk_rdata_hold: assert property (
    !(req && !wb_ack_o && !wb_we_i) |=> $stable(wb_dat_o))
    else $error("read data changed without a read");

  chk_pend_sticky: assert property (
    !(|evt_vec) && !evt_clr |=> $stable(pend_ff))
    else $error("pending bits changed without event or clear");

  cov_irq_rise: cover property (!irq_o ##1 irq_o);
  cov_nmi_rise: cover property (!nmi_o ##1 nmi_o);
  cov_set_then_clr: cover property (set_bit0 ##[1:20] clr_bit0);
  cov_evt_clr_race: cover property (evt_clr && (|(evt_vec & wb_dat_i)));
  cov_nmi_direct: cover property (nmi_kind == mwi_pkg::MWI_WR_DIRECT);

endmodule
`default_nettype wire

/* File: testbench/mwi_evt_src.sv */
`timescale 1ns/1ns
`default_nettype none

module mwi_evt_src (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic fire_i,
  input wire logic [5:0] wr_sel_i,
  input wire logic [5:0] rd_sel_i,
  output logic [5:0] write_hit_o,
  output logic [5:0] read_hit_o
);
  // Write and read hits leave the detector as separate pulses
  always_ff @(posedge clk_i) begin
    if (rst_i || !fire_i) begin
      write_hit_o <= 6'h00;
      read_hit_o <= 6'h00;
    end else begin
      write_hit_o <= wr_sel_i;
      read_hit_o <= rd_sel_i;
    end
  end
endmodule

`default_nettype wire

/* File: testbench/memory_watch_irq_enables_bench.sv */
`timescale 1ns/1ns
`default_nettype none
`include "mwi_map.svh"

module memory_watch_irq_enables_bench;
  logic clk_i;
  logic rst_i;
  logic cyc, stb, we, fire, ack, irq, nmi;
  logic [11:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q, t, bit1;
  logic [5:0] wsel, rsel, whit, rhit, w, r;
  logic [31:0] m_irq, m_nmi, m_pend;
  logic [11:0] ofs [6];
  int n_errors = 0;
  int samples_checked = 0;
  int seed = 32'h2017;

  mwi_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .evt_write_hit_i(whit),
    .evt_read_hit_i(rhit), .irq_o(irq), .nmi_o(nmi));

  mwi_evt_src src (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire),
    .wr_sel_i(wsel), .rd_sel_i(rsel), .write_hit_o(whit),
    .read_hit_o(rhit));

  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  function automatic logic [31:0] evt_bits(input logic [5:0] wv,
                                           input logic [5:0] rv);
    logic [31:0] b;
    b = 32'h00000000;
    for (int k = 0; k < 6; k++) begin
      b[(k < 4) ? 2 * k : 16 + 2 * k] = wv[k];
      b[((k < 4) ? 2 * k : 16 + 2 * k) + 1] = rv[k];
    end
    return b;
  endfunction

  function automatic logic [31:0] lanes(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  task automatic bus(input logic wr_en, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr_en;
    adr <= a;
    wdat <= d;
    sel <= s;
    // Only the watchdog ends a wait for ack
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    logic [31:0] bm;
    bm = lanes(s) & `MWI_VALID_BITS;
    bus(1'b1, a, d, s);
    case (a)
      `MWI_OFS_IRQ_MASK: m_irq = (m_irq & ~bm) | (d & bm);
      `MWI_OFS_IRQ_SET: m_irq = m_irq | (d & bm);
      `MWI_OFS_IRQ_CLR: m_irq = m_irq & ~(d & bm);
      `MWI_OFS_NMI_MASK: m_nmi = (m_nmi & ~bm) | (d & bm);
      `MWI_OFS_EVT_STAT: m_pend = m_pend & ~(d & bm);
      default: ;
    endcase
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h00000000, 4'hf);
    check("read data", q, exp);
  endtask

  task automatic pulse(input logic [5:0] wv, input logic [5:0] rv);
    @(posedge clk_i);
    wsel <= wv;
    rsel <= rv;
    fire <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
    repeat (4) @(posedge clk_i);
    m_pend = m_pend | evt_bits(wv, rv);
  endtask

  // Outputs are registered, so two edges pass before they are judged
  task automatic irq_chk();
    repeat (2) @(posedge clk_i);
    check("irq_o", {31'h0, irq}, {31'h0, |(m_pend & m_irq)});
    check("nmi_o", {31'h0, nmi}, {31'h0, |(m_pend & m_nmi)});
  endtask

  // Reset values at the first edge after release, then over the bus
  task automatic reset_chk();
    @(posedge clk_i);
    check("wb_ack_o", {31'h0, ack}, 32'h00000000);
    check("wb_dat_o", rdat, 32'h00000000);
    rd(`MWI_OFS_IRQ_MASK, 32'h00000000);
    rd(`MWI_OFS_NMI_MASK, 32'h00000000);
    rd(`MWI_OFS_EVT_STAT, 32'h00000000);
    irq_chk();
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    results();
  end

  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, fire} = 4'h0;
    adr = 12'h000;
    sel = 4'h0;
    wdat = 32'h00000000;
    {wsel, rsel} = 12'h000;
    {m_irq, m_nmi, m_pend} = 96'h0;
    ofs = '{`MWI_OFS_IRQ_MASK, `MWI_OFS_IRQ_SET, `MWI_OFS_IRQ_CLR,
            `MWI_OFS_NMI_MASK, `MWI_OFS_EVT_STAT, 12'h30c};
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    reset_chk();
    rd(12'h30c, 32'h00000000);
    $display("test reset done");
    // Each event alone; the opposite direction must not reach the irq
    for (int i = 0; i < 12; i++) begin
      w = (i % 2 == 0) ? 6'(1 << (i / 2)) : 6'h00;
      r = (i % 2 == 1) ? 6'(1 << (i / 2)) : 6'h00;
      bit1 = evt_bits(w, r);
      wr(`MWI_OFS_IRQ_SET, bit1, 4'hf);
      rd(`MWI_OFS_IRQ_SET, m_irq);
      wr(`MWI_OFS_NMI_MASK, (i % 3 == 0) ? bit1 : 32'h0, 4'hf);
      pulse(r, w);
      irq_chk();
      wr(`MWI_OFS_EVT_STAT, 32'hffffffff, 4'hf);
      pulse(w, r);
      irq_chk();
      rd(`MWI_OFS_EVT_STAT, m_pend);
      wr(`MWI_OFS_IRQ_CLR, bit1, 4'hf);
      rd(`MWI_OFS_IRQ_CLR, m_irq);
      irq_chk();
      wr(`MWI_OFS_EVT_STAT, 32'hffffffff, 4'hf);
    end
    $display("test single events done");
    // Random writes with sparse byte lanes leave many zero bits
    for (int i = 0; i < 40; i++) begin
      t = $random(seed);
      wr(ofs[t[2:0] % 6], $random(seed), t[7:4]);
      if (t[3]) pulse(t[13:8], t[19:14]);
      rd(`MWI_OFS_IRQ_MASK, m_irq);
      rd(`MWI_OFS_IRQ_SET, m_irq);
      rd(`MWI_OFS_IRQ_CLR, m_irq);
      rd(`MWI_OFS_NMI_MASK, m_nmi);
      irq_chk();
    end
    $display("test random done");
    // Event and its clear land on one edge: the event must stay pending
    wr(`MWI_OFS_EVT_STAT, 32'hffffffff, 4'hf);
    fork
      pulse(6'h01, 6'h20);
      wr(`MWI_OFS_EVT_STAT, 32'h00000001, 4'h1);
    join
    rd(`MWI_OFS_EVT_STAT, m_pend);
    irq_chk();
    $display("test event clear race done");
    // Reset in mid-run must drop every enable and pending bit
    wr(`MWI_OFS_IRQ_MASK, 32'hffffffff, 4'hf);
    wr(`MWI_OFS_NMI_MASK, 32'hffffffff, 4'hf);
    pulse(6'h3f, 6'h3f);
    irq_chk();
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    {m_irq, m_nmi, m_pend} = 96'h0;
    reset_chk();
    $display("test mid-run reset done");
    results();
  end
endmodule

`default_nettype wire
